// file: dsv_pkg.sv
`default_nettype none
package dsv_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned mclk_hz = 10_000_000;
  localparam int unsigned scl_max_hz = 400_000;
  localparam int unsigned scl_min_period_cycles = mclk_hz / scl_max_hz;

  // ---------------------------------------------------------------
  // target address, register layout, reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] addr_base = 7'h08;
  localparam int range_bit = 3;
  localparam int vsel_w = 4;
  localparam logic [7:0] first_data_register_reset = 8'h00;
  localparam logic [3:0] vsel_standby = 4'h0;
  localparam logic [5:0] status_pad = 6'h00;

  // ---------------------------------------------------------------
  // nominal output per code, millivolts
  // ---------------------------------------------------------------
  localparam int mv_w = 15;
  localparam logic [14:0] mv_low_min = 15'h32c8;
  localparam logic [14:0] mv_low_max = 15'h3a98;
  localparam logic [14:0] mv_high_min = 15'h46e6;
  localparam logic [14:0] mv_high_max = 15'h5003;
  localparam logic [14:0] nom_mv_tab [16] = '{
    15'h0000, 15'h32c8, 15'h3415, 15'h3563, 15'h36b0, 15'h37fd, 15'h394b, 15'h3a98,
    15'h46e6, 15'h4833, 15'h4981, 15'h4ace, 15'h4c1b, 15'h4d69, 15'h4eb6, 15'h5003
  };
  // undervoltage threshold as a fraction of nominal
  localparam logic [3:0] uv_num = 4'h9;
  localparam logic [18:0] uv_den = 19'h0000a;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ph_idle, ph_addr, ph_wr, ph_rd, ph_skip} dsv_state_e;

  typedef struct packed {
    logic en;
    logic high_range;
    logic [2:0] level;
    logic [14:0] nom_mv;
  } dsv_chan_s;

endpackage
`default_nettype wire

// file: dsv_supply_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - each channel has fifteen output levels picked by its own four-bit select field.
// - the top select bit picks the low range of seven levels or the high range of eight.
// - an all-zero select field turns that channel's output off and puts it in standby.
// - codes 1 to 7 give 13.000 V to 15.000 V in steps of about a third of a volt.
// - codes 8 to 15 give 18.150 V to 20.483 V in steps of about a third of a volt.
// - both channels use the same code table, each from its own select bits.
// - the serial clock runs at no more than 400 kHz.
// - with the strap low the device answers target address 0001000.
// - with the strap high the device answers target address 0001001.
// - the bit after the address asks for a read when one and a write when zero.
// - a channel's undervoltage flag is one while its output is below the low threshold.
// - the threshold is about 90 percent of nominal; the flag is zero above it.
module dsv_supply_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap,
  input wire logic [1:0][14:0] meas_mv,
  output logic [7:0] first_data_register,
  output dsv_pkg::dsv_chan_s [1:0] channel_supply_output,
  output logic [1:0] output_undervoltage_flag
);

  // ---------------------------------------------------------------
  // link domain: bits are taken on the rising serial clock
  // ---------------------------------------------------------------
  // held stable for a whole clock period, read by the core only
  // after it has seen the synchronised rising edge
  logic [7:0] link_shift;

  always_ff @(posedge scl) begin
    link_shift <= {link_shift[6:0], sda_in};
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] strap_s;
  logic scl_p;
  logic sda_p;

  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      strap_s <= 2'h0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl};
      sda_s <= {sda_s[0], sda_in};
      strap_s <= {strap_s[0], addr_strap};
      scl_p <= scl_s[1];
      sda_p <= sda_s[1];
    end
  end

  // scl high lasts several mclk periods at the top link rate, so no
  // start, stop or edge is missed
  logic bit_evt;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] dev_addr;

  assign bit_evt = scl_s[1] & ~scl_p;
  assign scl_fall = ~scl_s[1] & scl_p;
  assign start_det = scl_s[1] & scl_p & sda_p & ~sda_s[1];
  assign stop_det = scl_s[1] & scl_p & ~sda_p & sda_s[1];
  assign dev_addr = {dsv_pkg::addr_base[6:1], strap_s[1]};

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  dsv_pkg::dsv_state_e state;
  logic [3:0] bit_cnt;
  logic rw;
  logic ack_pend;
  logic [7:0] wr_hold;
  logic [7:0] rd_sh;
  logic [7:0] status_byte;
  logic commit;

  assign status_byte = {dsv_pkg::status_pad, output_undervoltage_flag};
  assign commit = bit_evt & (state == dsv_pkg::ph_wr) & (bit_cnt == 4'h8);

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= dsv_pkg::ph_idle;
      bit_cnt <= 4'h0;
      rw <= 1'b0;
      ack_pend <= 1'b0;
      wr_hold <= 8'h00;
      rd_sh <= 8'h00;
    end else if (start_det) begin
      state <= dsv_pkg::ph_addr;
      bit_cnt <= 4'h0;
      ack_pend <= 1'b0;
    end else if (stop_det) begin
      state <= dsv_pkg::ph_idle;
      ack_pend <= 1'b0;
    end else begin
      if (scl_fall) begin
        ack_pend <= 1'b0;
      end
      if (bit_evt) begin
        case (state)
          dsv_pkg::ph_addr: begin
            if (bit_cnt == 4'h7) begin
              bit_cnt <= 4'h8;
              if (link_shift[7:1] == dev_addr) begin
                ack_pend <= 1'b1;
                rw <= link_shift[0];
              end else begin
                state <= dsv_pkg::ph_skip;
              end
            end else if (bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              state <= rw ? dsv_pkg::ph_rd : dsv_pkg::ph_wr;
              rd_sh <= status_byte;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          dsv_pkg::ph_wr: begin
            if (bit_cnt == 4'h7) begin
              bit_cnt <= 4'h8;
              ack_pend <= 1'b1;
              wr_hold <= link_shift;
            end else if (bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          dsv_pkg::ph_rd: begin
            if (bit_cnt == 4'h8) begin
              // a not-acknowledge from the host ends the read
              if (link_shift[0]) begin
                state <= dsv_pkg::ph_skip;
              end else begin
                bit_cnt <= 4'h0;
                rd_sh <= status_byte;
              end
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // data line drive: changes only while scl is low
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (start_det || stop_det) begin
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (ack_pend) begin
          sda_oe <= 1'b1;
        end else if (state == dsv_pkg::ph_rd && bit_cnt != 4'h8) begin
          sda_oe <= ~rd_sh[3'(4'h7 - bit_cnt)];
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // voltage select register
  // ---------------------------------------------------------------
  // both fields land in one clock so the channels never see half a write
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_data_register <= dsv_pkg::first_data_register_reset;
    end else if (commit) begin
      first_data_register <= wr_hold;
    end
  end

  // ---------------------------------------------------------------
  // per channel decode and undervoltage monitor
  // ---------------------------------------------------------------
  // the measured word comes from a slow converter and changes far less
  // often than mclk; a torn sample lasts one cycle at most
  logic [1:0][14:0] meas_s1;
  logic [1:0][14:0] meas_s2;
  logic [1:0][14:0] uv_thr;
  logic [1:0][3:0] vsel;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_chan
      logic [18:0] prod;

      assign vsel[i] = first_data_register[i*dsv_pkg::vsel_w +: dsv_pkg::vsel_w];
      assign prod = channel_supply_output[i].nom_mv * dsv_pkg::uv_num;
      assign uv_thr[i] = 15'(prod / dsv_pkg::uv_den);

      always_ff @(posedge mclk) begin
        if (rst) begin
          channel_supply_output[i] <= '0;
        end else begin
          channel_supply_output[i].en <= vsel[i] != dsv_pkg::vsel_standby;
          channel_supply_output[i].high_range <= vsel[i][dsv_pkg::range_bit];
          channel_supply_output[i].level <= vsel[i][2:0];
          channel_supply_output[i].nom_mv <= dsv_pkg::nom_mv_tab[vsel[i]];
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          meas_s1[i] <= 15'h0000;
          meas_s2[i] <= 15'h0000;
          output_undervoltage_flag[i] <= 1'b0;
        end else begin
          meas_s1[i] <= meas_mv[i];
          meas_s2[i] <= meas_s1[i];
          // no diagnostic on a channel in standby
          output_undervoltage_flag[i] <= channel_supply_output[i].en &
                                         (meas_s2[i] < uv_thr[i]);
        end
      end

      standby_off_a: assert property (@(posedge mclk) disable iff (rst)
        vsel[i] == dsv_pkg::vsel_standby |=> !channel_supply_output[i].en)
        else $error("channel left on with a zero select field");
      range_pick_a: assert property (@(posedge mclk) disable iff (rst)
        ##1 channel_supply_output[i].high_range ==
        $past(first_data_register[i*dsv_pkg::vsel_w + dsv_pkg::range_bit]))
        else $error("range bit not followed");
      level_count_a: assert property (@(posedge mclk) disable iff (rst)
        $past(vsel[i]) != 4'h0 |-> (channel_supply_output[i].en &&
        channel_supply_output[i].nom_mv != $past(channel_supply_output[i].nom_mv)) ||
        $past(vsel[i]) == $past(vsel[i], 2))
        else $error("nonzero code did not give its own level");
      low_span_a: assert property (@(posedge mclk) disable iff (rst)
        channel_supply_output[i].en && !channel_supply_output[i].high_range |->
        channel_supply_output[i].nom_mv inside {[dsv_pkg::mv_low_min:dsv_pkg::mv_low_max]})
        else $error("low range level out of span");
      high_span_a: assert property (@(posedge mclk) disable iff (rst)
        channel_supply_output[i].en && channel_supply_output[i].high_range |->
        channel_supply_output[i].nom_mv inside {[dsv_pkg::mv_high_min:dsv_pkg::mv_high_max]})
        else $error("high range level out of span");
      uv_set_a: assert property (@(posedge mclk) disable iff (rst)
        channel_supply_output[i].en && meas_s2[i] < uv_thr[i] |=>
        output_undervoltage_flag[i])
        else $error("undervoltage not flagged");
      uv_clear_a: assert property (@(posedge mclk) disable iff (rst)
        meas_s2[i] >= uv_thr[i] |=> !output_undervoltage_flag[i])
        else $error("flag set above threshold");
    end
  endgenerate

  // ---------------------------------------------------------------
  // checks on the serial side and across the two channels
  // ---------------------------------------------------------------
  chan_same_a: assert property (@(posedge mclk) disable iff (rst)
    vsel[0] == vsel[1] [*2] |-> channel_supply_output[0] == channel_supply_output[1])
    else $error("channels decode the same code differently");
  addr_match_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ack_pend) && state == dsv_pkg::ph_addr |->
    link_shift[7:1] == (dsv_pkg::addr_base | {6'h00, strap_s[1]}))
    else $error("acked a foreign address");
  // the ack has to reach the line in the low phase right after the eighth bit
  ack_drive_a: assert property (@(posedge mclk) disable iff (rst)
    ack_pend && scl_fall && state == dsv_pkg::ph_addr && !strap_s[1] |=> sda_oe)
    else $error("address ack not driven");
  strap_high_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ack_pend) && state == dsv_pkg::ph_addr && strap_s[1] |-> link_shift[1])
    else $error("strap high but low address acked");
  rw_dir_a: assert property (@(posedge mclk) disable iff (rst)
    state == dsv_pkg::ph_rd |-> rw)
    else $error("read phase entered on a write request");
  commit_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(first_data_register) |-> $past(commit) && $past(bit_cnt) == 4'h8)
    else $error("select fields changed outside an acked write");

  wr_commit_c: cover property (@(posedge mclk) disable iff (rst) commit);
  rd_byte_c: cover property (@(posedge mclk) disable iff (rst)
    state == dsv_pkg::ph_rd && bit_cnt == 4'h8 && bit_evt);
  standby_c: cover property (@(posedge mclk) disable iff (rst)
    $fell(channel_supply_output[0].en));
  uv_c: cover property (@(posedge mclk) disable iff (rst) $rose(output_undervoltage_flag[1]));

endmodule
`default_nettype wire

// file: dsv_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsv_host_model #(
  parameter int half_ns = 1300
) (
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ---------------------------------------------------------------
  // serial host phases
  // ---------------------------------------------------------------
  // scl stands high between frames; sda moves a quarter phase after scl falls
  // so the target never mistakes a data change for a start or stop
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic start();
    sda_pull = 1'b0;
    #(half_ns) scl = 1'b1;
    #(half_ns) sda_pull = 1'b1;
    #(half_ns) scl = 1'b0;
  endtask

  // 2 x 1300 ns per bit keeps scl below 400 kHz
  task automatic clock_bit(input logic b, output logic seen);
    #(half_ns / 4) sda_pull = !b;
    #(half_ns * 3 / 4) scl = 1'b1;
    #(half_ns / 2) seen = sda;
    #(half_ns / 2) scl = 1'b0;
  endtask

  // address byte carries the direction bit in bit 0
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(v[i], s);
    end
    clock_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, v[i]);
    end
    clock_bit(last, s);
  endtask

  task automatic stop();
    #(half_ns / 4) sda_pull = 1'b1;
    #(half_ns * 3 / 4) scl = 1'b1;
    #(half_ns) sda_pull = 1'b0;
    #(half_ns);
  endtask
endmodule
`default_nettype wire

// file: dish_supply_voltage_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dish_supply_voltage_control_tb;
  logic mclk, rst, addr_strap, sda_out, sda_oe, scl, host_pull, sda_line;
  logic [1:0][14:0] meas_mv;
  logic [7:0] first_data_register;
  dsv_pkg::dsv_chan_s [1:0] channel_supply_output;
  logic [1:0] output_undervoltage_flag;
  int n_mismatch = 0;
  int checked = 0;
  localparam logic [14:0] meas_a [4] = '{15'h2db3, 15'h2db4, 15'h32c8, 15'h0000};
  localparam logic [14:0] meas_b [4] = '{15'h3fcf, 15'h3fce, 15'h46e6, 15'h0000};
  localparam logic [1:0] flag_exp [4] = '{2'h1, 2'h2, 2'h0, 2'h3};

  // open-drain data line with a pull-up
  assign sda_line = !((sda_oe && !sda_out) || host_pull);

  dsv_supply_ctrl u_dut (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .meas_mv(meas_mv),
    .first_data_register(first_data_register),
    .channel_supply_output(channel_supply_output),
    .output_undervoltage_flag(output_undervoltage_flag)
  );
  dsv_host_model u_host (.sda(sda_line), .scl(scl), .sda_pull(host_pull));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic exp_ack);
    logic a1, a2;
    u_host.start();
    u_host.send_byte({a, 1'b0}, a1);
    u_host.send_byte(d, a2);
    u_host.stop();
    repeat (4) @(negedge mclk);
    check(20'(a1), 20'(exp_ack));
    check(20'(a2), 20'(exp_ack));
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic ack;
    logic [7:0] v;
    u_host.start();
    u_host.send_byte({a, 1'b1}, ack);
    u_host.recv_byte(1'b1, v);
    u_host.stop();
    repeat (4) @(negedge mclk);
    check(20'(ack), 20'h00001);
    check(20'(v), 20'(exp));
  endtask

  // nominal millivolts worked out from the range start and a third-volt step
  function automatic dsv_pkg::dsv_chan_s exp_chan(input logic [3:0] c);
    dsv_pkg::dsv_chan_s s;
    int mv;
    mv = 0;
    if (c != 4'h0 && !c[3]) mv = 13000 + ((int'(c) - 1) * 1000 + 1) / 3;
    if (c[3]) mv = 18150 + ((int'(c) - 8) * 1000 + 1) / 3;
    s.en = (c != 4'h0);
    s.high_range = c[3];
    s.level = c[2:0];
    s.nom_mv = 15'(mv);
    return s;
  endfunction

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    addr_strap = 1'b0;
    meas_mv = '0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    check(20'(first_data_register), 20'h00000);
    check(channel_supply_output[0], 20'h00000);
    check(20'(output_undervoltage_flag), 20'h00000);
    for (int c = 0; c < 16; c++) begin
      wr(7'h08, {4'(15 - c), 4'(c)}, 1'b1);
      check(20'(first_data_register), {12'h000, 4'(15 - c), 4'(c)});
      check(channel_supply_output[0], exp_chan(4'(c)));
      check(channel_supply_output[1], exp_chan(4'(15 - c)));
    end
    wr(7'h08, 8'h81, 1'b1);
    for (int k = 0; k < 4; k++) begin
      meas_mv[0] = meas_a[k];
      meas_mv[1] = meas_b[k];
      repeat (8) @(negedge mclk);
      check(20'(output_undervoltage_flag), 20'(flag_exp[k]));
      rd(7'h08, {6'h00, flag_exp[k]});
    end
    wr(7'h08, 8'h00, 1'b1);
    check(20'(output_undervoltage_flag), 20'h00000);
    addr_strap = 1'b1;
    repeat (4) @(negedge mclk);
    wr(7'h08, 8'h55, 1'b0);
    check(20'(first_data_register), 20'h00000);
    wr(7'h09, 8'h37, 1'b1);
    check(20'(first_data_register), 20'h00037);
    rd(7'h09, 8'h03);
    addr_strap = 1'b0;
    repeat (4) @(negedge mclk);
    wr(7'h09, 8'h11, 1'b0);
    check(20'(first_data_register), 20'h00037);
    complete_run();
  end

  initial begin
    #5_000_000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
